/* common/rot_pkg.sv */
package rot_pkg;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int         WB_ADDR_W   = 8;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CODE    = 8'h04;
  localparam logic [7:0] OFF_BCDE    = 8'h08;
  localparam logic [7:0] OFF_HLAF    = 8'h0C;
  localparam logic [7:0] OFF_INDEX   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam int         CTRL_START  = 0;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_DONE     = 1;
  localparam int         ST_BAD      = 2;
  localparam int         ST_MCYC_LSB = 4;
  localparam int         ST_TCNT_LSB = 8;

  // flag byte layout
  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  // ----------------------------------------------------------------
  // code bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] PFX_CB   = 8'hCB;
  localparam logic [7:0] PFX_IDX1 = 8'hDD;
  localparam logic [7:0] PFX_IDX2 = 8'hFD;
  localparam logic [4:0] GRP_RLC  = 5'h00;
  localparam logic [4:0] GRP_RRC  = 5'h01;
  localparam logic [4:0] GRP_RL   = 5'h02;
  localparam logic [4:0] GRP_RR   = 5'h03;
  localparam logic [2:0] SEL_B    = 3'h0;
  localparam logic [2:0] SEL_C    = 3'h1;
  localparam logic [2:0] SEL_D    = 3'h2;
  localparam logic [2:0] SEL_E    = 3'h3;
  localparam logic [2:0] SEL_H    = 3'h4;
  localparam logic [2:0] SEL_L    = 3'h5;
  localparam logic [2:0] SEL_MEM  = 3'h6;
  localparam logic [2:0] SEL_A    = 3'h7;

  typedef enum logic [1:0] {OP_RLC, OP_RRC, OP_RL, OP_RR} rot_op_t;
  typedef enum logic [1:0] {FORM_REG, FORM_PTR, FORM_IDX} form_t;

  // ----------------------------------------------------------------
  // machine-cycle timing, one clock per clock state
  // ----------------------------------------------------------------
  localparam logic [2:0] T_STD       = 3'h4;
  localparam logic [2:0] T_SHORT     = 3'h3;
  localparam logic [2:0] T_LONG      = 3'h5;
  localparam logic [2:0] M_CNT_REG   = 3'h2;
  localparam logic [2:0] M_CNT_PTR   = 3'h4;
  localparam logic [2:0] M_CNT_IDX   = 3'h6;
  localparam logic [2:0] M_PTR_READ  = 3'h2;
  localparam logic [2:0] M_PTR_WRITE = 3'h3;
  localparam logic [2:0] M_IDX_DISP  = 3'h2;
  localparam logic [2:0] M_IDX_ADD   = 3'h3;
  localparam logic [2:0] M_IDX_READ  = 3'h4;
  localparam logic [2:0] M_IDX_WRITE = 3'h5;

  function automatic logic [2:0] t_len(form_t f, logic [2:0] m);
    logic [2:0] len;
    len = T_STD;
    if (f == FORM_PTR && m == M_PTR_WRITE)
      len = T_SHORT;
    if (f == FORM_IDX && (m == M_IDX_DISP || m == M_IDX_WRITE))
      len = T_SHORT;
    if (f == FORM_IDX && m == M_IDX_ADD)
      len = T_LONG;
    return len;
  endfunction : t_len

  function automatic logic [2:0] m_count(form_t f);
    return (f == FORM_IDX) ? M_CNT_IDX : ((f == FORM_PTR) ? M_CNT_PTR : M_CNT_REG);
  endfunction : m_count

endpackage : rot_pkg

/* core/mcycle_timer.sv */
`timescale 1ns/1ps
module mcycle_timer (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            start_i,
  input  rot_pkg::form_t       form_i,
  output logic                 busy_o,
  output logic [2:0]           mcycle_o,
  output logic                 mcycle_end_o,
  output logic                 done_o
);
  typedef struct packed {
    logic           busy;
    rot_pkg::form_t form;
    logic [2:0]     m;
    logic [2:0]     t;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  assign busy_o       = s_q.busy;
  assign mcycle_o     = s_q.m;
  assign mcycle_end_o = s_q.busy && (s_q.t == rot_pkg::t_len(s_q.form, s_q.m) - 3'h1);
  assign done_o       = mcycle_end_o && (s_q.m == rot_pkg::m_count(s_q.form) - 3'h1);

  always_comb
  begin
    s_d = s_q;
    if (!s_q.busy)
    begin
      if (start_i)
      begin
        s_d.busy = 1'b1;
        s_d.form = form_i;
        s_d.m    = 3'h0;
        s_d.t    = 3'h0;
      end
    end
    else if (done_o)
      s_d.busy = 1'b0;
    else if (mcycle_end_o)
    begin
      s_d.m = s_q.m + 3'h1;
      s_d.t = 3'h0;
    end
    else
      s_d.t = s_q.t + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule : mcycle_timer

/* core/rotate_core.sv */
`timescale 1ns/1ps
module rotate_core (
  input  rot_pkg::rot_op_t op_i,
  input  wire logic [7:0]  operand_i,
  input  wire logic [7:0]  flags_i,
  output logic [7:0]       result_o,
  output logic [7:0]       flags_o
);
  always_comb
  begin
    case (op_i)
      rot_pkg::OP_RLC: result_o = {operand_i[6:0], operand_i[7]};
      rot_pkg::OP_RL:  result_o = {operand_i[6:0], flags_i[rot_pkg::FLAG_C]};
      rot_pkg::OP_RRC: result_o = {operand_i[0], operand_i[7:1]};
      rot_pkg::OP_RR:  result_o = {flags_i[rot_pkg::FLAG_C], operand_i[7:1]};
      default:         result_o = operand_i;
    endcase
    // the two undocumented flag bits pass through untouched
    flags_o = flags_i;
    if (op_i == rot_pkg::OP_RLC || op_i == rot_pkg::OP_RL)
      flags_o[rot_pkg::FLAG_C] = operand_i[7];
    else
      flags_o[rot_pkg::FLAG_C] = operand_i[0];
    flags_o[rot_pkg::FLAG_S] = result_o[7];
    flags_o[rot_pkg::FLAG_Z] = (result_o == 8'h00);
    flags_o[rot_pkg::FLAG_PV] = ~^result_o;
    flags_o[rot_pkg::FLAG_H]  = 1'b0;
    flags_o[rot_pkg::FLAG_N]  = 1'b0;
  end
endmodule : rotate_core

/* core/byte_rotate_unit.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// byte rotate unit
// ------------------------------------------------------------------
// Behaviour
// - circular left, bit 7 to carry and bit 0
// - left through carry, old carry to bit 0
// - circular right, bit 0 to carry and bit 7
// - right through carry, old carry to bit 7
// - either index plus signed displacement addresses byte
// - three operand forms, indexed use prefix, CB, d, op
// - low three bits select register, 110 is memory
// - operation groups by upper five opcode bits
// - 8, 15 or 23 clock states per form
// - sign equals result bit 7
// - zero set when result is zero
// - parity even sets flag; half, subtract cleared
// - pointer form addresses through pointer pair
module byte_rotate_unit (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [rot_pkg::WB_ADDR_W-1:0] adr_i,
  input  wire logic [31:0]                   dat_i,
  output logic [31:0]                        dat_o,
  input  wire logic                          we_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  output logic                               ack_o,
  output logic [15:0]                        mem_addr_o,
  output logic                               mem_rd_o,
  output logic                               mem_wr_o,
  output logic [7:0]                         mem_wdata_o,
  input  wire logic [7:0]                    mem_rdata_i,
  output logic                               busy_o
);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             ok;
    rot_pkg::form_t   form;
    rot_pkg::rot_op_t op;
    logic [2:0]       sel;
    logic             use_two;
    logic [7:0]       disp;
  } decode_t;

  typedef struct packed {
    logic [7:0]       b;
    logic [7:0]       c;
    logic [7:0]       d;
    logic [7:0]       e;
    logic [7:0]       h;
    logic [7:0]       l;
    logic [7:0]       a;
    logic [7:0]       f;
    logic [15:0]      index_reg_one;
    logic [15:0]      index_reg_two;
    logic [31:0]      code;
    rot_pkg::form_t   form;
    rot_pkg::rot_op_t op;
    logic [2:0]       sel;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic [7:0]       flags_pend;
    logic             done;
    logic             bad;
    logic [7:0]       tcount;
    logic [7:0]       last_tcount;
    logic             ack;
    logic [31:0]      rdata;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;
  decode_t     dec;
  logic        wb_take;
  logic        start_go;
  logic        t_busy;
  logic [2:0]  t_mcycle;
  logic        t_mend;
  logic        t_done;
  logic [7:0]  core_operand;
  logic [7:0]  core_result;
  logic [7:0]  core_flags;
  logic [2:0]  rd_mcycle;
  logic [2:0]  wr_mcycle;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic decode_t decode_code(logic [31:0] code);
    decode_t    dc;
    logic [7:0] op_byte;
    dc      = '0;
    op_byte = code[15:8];
    if (code[7:0] == rot_pkg::PFX_CB)
    begin
      dc.ok = 1'b1;
      dc.form = (op_byte[2:0] == rot_pkg::SEL_MEM) ? rot_pkg::FORM_PTR : rot_pkg::FORM_REG;
    end
    else if ((code[7:0] == rot_pkg::PFX_IDX1 || code[7:0] == rot_pkg::PFX_IDX2) &&
             code[15:8] == rot_pkg::PFX_CB)
    begin
      op_byte    = code[31:24];
      dc.ok      = (op_byte[2:0] == rot_pkg::SEL_MEM);
      dc.form    = rot_pkg::FORM_IDX;
      dc.use_two = (code[7:0] == rot_pkg::PFX_IDX2);
      dc.disp    = code[23:16];
    end
    dc.sel = op_byte[2:0];
    case (op_byte[7:3])
      rot_pkg::GRP_RLC: dc.op = rot_pkg::OP_RLC;
      rot_pkg::GRP_RRC: dc.op = rot_pkg::OP_RRC;
      rot_pkg::GRP_RL:  dc.op = rot_pkg::OP_RL;
      rot_pkg::GRP_RR:  dc.op = rot_pkg::OP_RR;
      default:          dc.ok = 1'b0;
    endcase
    return dc;
  endfunction : decode_code

  function automatic logic [7:0] reg_read(unit_state_t s, logic [2:0] sel);
    logic [7:0] v;
    case (sel)
      rot_pkg::SEL_B: v = s.b;
      rot_pkg::SEL_C: v = s.c;
      rot_pkg::SEL_D: v = s.d;
      rot_pkg::SEL_E: v = s.e;
      rot_pkg::SEL_H: v = s.h;
      rot_pkg::SEL_L: v = s.l;
      rot_pkg::SEL_A: v = s.a;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  function automatic unit_state_t reg_write(unit_state_t s, logic [2:0] sel, logic [7:0] v);
    unit_state_t r;
    r = s;
    case (sel)
      rot_pkg::SEL_B: r.b = v;
      rot_pkg::SEL_C: r.c = v;
      rot_pkg::SEL_D: r.d = v;
      rot_pkg::SEL_E: r.e = v;
      rot_pkg::SEL_H: r.h = v;
      rot_pkg::SEL_L: r.l = v;
      rot_pkg::SEL_A: r.a = v;
      default:        r = s;
    endcase
    return r;
  endfunction : reg_write

  function automatic logic [31:0] merge_bytes(logic [31:0] old, logic [31:0] nw,
                                              logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge_bytes

  function automatic logic hit(logic [rot_pkg::WB_ADDR_W-1:0] adr, logic [7:0] off);
    return adr[rot_pkg::WB_ADDR_W-1:2] == off[rot_pkg::WB_ADDR_W-1:2];
  endfunction : hit

  // a start needs the low byte lane and the start bit together
  function automatic logic start_request(logic [rot_pkg::WB_ADDR_W-1:0] adr, logic [3:0] be,
                                         logic [31:0] wd);
    return hit(adr, rot_pkg::OFF_CTRL) && be[0] && wd[rot_pkg::CTRL_START];
  endfunction : start_request

  function automatic logic [15:0] sext_disp(logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction : sext_disp

  // operand registers honour byte lanes; callers keep them frozen while running
  function automatic unit_state_t write_regs(unit_state_t s,
                                             logic [rot_pkg::WB_ADDR_W-1:0] adr,
                                             logic [31:0] wd, logic [3:0] be);
    unit_state_t r;
    r = s;
    if (hit(adr, rot_pkg::OFF_CODE))
      r.code = merge_bytes(s.code, wd, be);
    if (hit(adr, rot_pkg::OFF_BCDE))
      {r.b, r.c, r.d, r.e} = merge_bytes({s.b, s.c, s.d, s.e}, wd, be);
    if (hit(adr, rot_pkg::OFF_HLAF))
      {r.h, r.l, r.a, r.f} = merge_bytes({s.h, s.l, s.a, s.f}, wd, be);
    if (hit(adr, rot_pkg::OFF_INDEX))
      {r.index_reg_two, r.index_reg_one} =
        merge_bytes({s.index_reg_two, s.index_reg_one}, wd, be);
    return r;
  endfunction : write_regs

  // unmapped words and the start register read zero
  function automatic logic [31:0] read_word(unit_state_t s,
                                            logic [rot_pkg::WB_ADDR_W-1:0] adr,
                                            logic bsy, logic [2:0] mcyc);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(adr, rot_pkg::OFF_CODE))
      w = s.code;
    if (hit(adr, rot_pkg::OFF_BCDE))
      w = {s.b, s.c, s.d, s.e};
    if (hit(adr, rot_pkg::OFF_HLAF))
      w = {s.h, s.l, s.a, s.f};
    if (hit(adr, rot_pkg::OFF_INDEX))
      w = {s.index_reg_two, s.index_reg_one};
    if (hit(adr, rot_pkg::OFF_STATUS))
    begin
      w[rot_pkg::ST_BUSY]          = bsy;
      w[rot_pkg::ST_DONE]          = s.done;
      w[rot_pkg::ST_BAD]           = s.bad;
      w[rot_pkg::ST_MCYC_LSB +: 3] = mcyc;
      w[rot_pkg::ST_TCNT_LSB +: 8] = s.last_tcount;
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  assign dec = decode_code(s_q.code);

  mcycle_timer u_timer (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .start_i      (start_go),
    .form_i       (dec.form),
    .busy_o       (t_busy),
    .mcycle_o     (t_mcycle),
    .mcycle_end_o (t_mend),
    .done_o       (t_done)
  );

  // memory forms take the byte straight off the read data in its last state
  assign core_operand = (s_q.form == rot_pkg::FORM_REG) ? reg_read(s_q, s_q.sel) : mem_rdata_i;

  rotate_core u_core (
    .op_i      (s_q.op),
    .operand_i (core_operand),
    .flags_i   (s_q.f),
    .result_o  (core_result),
    .flags_o   (core_flags)
  );

  assign rd_mcycle = (s_q.form == rot_pkg::FORM_IDX) ? rot_pkg::M_IDX_READ : rot_pkg::M_PTR_READ;
  assign wr_mcycle = (s_q.form == rot_pkg::FORM_IDX) ? rot_pkg::M_IDX_WRITE : rot_pkg::M_PTR_WRITE;

  // ----------------------------------------------------------------
  // bus and sequencing
  // ----------------------------------------------------------------
  assign wb_take  = cyc_i && stb_i && !s_q.ack;
  assign start_go = wb_take && we_i && start_request(adr_i, sel_i, dat_i) && !t_busy &&
                    dec.ok;

  always_comb
  begin
    s_d     = s_q;
    // one pulse per access; a strobe still high after ack is not taken again
    s_d.ack = wb_take;

    // ---- bus writes; operand state is frozen while running ----
    if (wb_take && we_i)
    begin
      if (start_request(adr_i, sel_i, dat_i) && !t_busy)
      begin
        s_d.done = 1'b0;
        s_d.bad  = !dec.ok;
        if (dec.ok)
        begin
          s_d.form   = dec.form;
          s_d.op     = dec.op;
          s_d.sel    = dec.sel;
          s_d.tcount = 8'h00;
          s_d.addr = {s_q.h, s_q.l};
          if (dec.form == rot_pkg::FORM_IDX)
            s_d.addr = (dec.use_two ? s_q.index_reg_two : s_q.index_reg_one) +
                       sext_disp(dec.disp);
        end
      end
      // a refused write is still acknowledged so the master never stalls
      else if (!t_busy)
        s_d = write_regs(s_d, adr_i, dat_i, sel_i);
    end

    // ---- bus reads ----
    if (wb_take)
      s_d.rdata = read_word(s_q, adr_i, t_busy, t_mcycle);

    // ---- execution ----
    if (t_busy)
    begin
      s_d.tcount = s_q.tcount + 8'h01;
      // latch rotated byte at end of read
      if (s_q.form != rot_pkg::FORM_REG && t_mend && t_mcycle == rd_mcycle)
      begin
        s_d.wdata      = core_result;
        s_d.flags_pend = core_flags;
      end
      if (t_done)
      begin
        s_d.done        = 1'b1;
        s_d.last_tcount = s_q.tcount + 8'h01;
        if (s_q.form == rot_pkg::FORM_REG)
        begin
          s_d   = reg_write(s_d, s_q.sel, core_result);
          s_d.f = core_flags;
        end
        else
          s_d.f = s_q.flags_pend;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ack_o       = s_q.ack;
  assign dat_o       = s_q.rdata;
  assign busy_o      = t_busy;
  assign mem_addr_o  = s_q.addr;
  assign mem_wdata_o = s_q.wdata;
  assign mem_rd_o = t_busy && s_q.form != rot_pkg::FORM_REG && t_mcycle == rd_mcycle;
  assign mem_wr_o = t_busy && s_q.form != rot_pkg::FORM_REG && t_mcycle == wr_mcycle;

endmodule : byte_rotate_unit

/* verification/byte_rotate_unit_checker.sv */
`timescale 1ns/1ps
module byte_rotate_unit_checker (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic [rot_pkg::WB_ADDR_W-1:0] adr_i,
  input wire logic [31:0]                   dat_i,
  input wire logic [31:0]                   dat_o,
  input wire logic                          we_i,
  input wire logic [3:0]                    sel_i,
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic                          ack_o,
  input wire logic [15:0]                   mem_addr_o,
  input wire logic                          mem_rd_o,
  input wire logic                          mem_wr_o,
  input wire logic [7:0]                    mem_wdata_o,
  input wire logic [7:0]                    mem_rdata_i,
  input wire logic                          busy_o
);
  // ------------------------------------------------------------
  // busy length counter
  // ------------------------------------------------------------
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  assign cnt_d = busy_o ? cnt_q + 5'h01 : 5'h00;
  always_ff @(posedge clk_i)
    cnt_q <= rst_i ? 5'h00 : cnt_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_busy_len: assert property ($fell(busy_o) && !$past(rst_i) |->
    cnt_q == 5'h08 || cnt_q == 5'h0F || cnt_q == 5'h17) else $error("bad busy length");
  a_read_start: assert property ($rose(mem_rd_o) |->
    cnt_q == 5'h08 || cnt_q == 5'h10) else $error("read cycle misplaced");
  a_read_len: assert property ($rose(mem_rd_o) |->
    mem_rd_o [*4] ##1 (!mem_rd_o && mem_wr_o)) else $error("read cycle length");
  a_write_len: assert property ($rose(mem_wr_o) |->
    mem_wr_o [*3] ##1 !mem_wr_o) else $error("write cycle length");
  a_write_last: assert property ($fell(mem_wr_o) |-> !busy_o)
    else $error("write not last");
  a_addr_same: assert property (mem_wr_o && $past(mem_rd_o || mem_wr_o) |->
    $stable(mem_addr_o)) else $error("write address moved");
  a_data_hold: assert property (mem_wr_o && $past(mem_wr_o) |->
    $stable(mem_wdata_o)) else $error("write data moved");
  a_mem_busy: assert property (mem_rd_o || mem_wr_o |-> busy_o)
    else $error("memory access while idle");
endmodule : byte_rotate_unit_checker

bind byte_rotate_unit byte_rotate_unit_checker i_chk (.clk_i, .rst_i, .adr_i, .dat_i,
  .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .mem_addr_o, .mem_rd_o, .mem_wr_o,
  .mem_wdata_o, .mem_rdata_i, .busy_o);

/* verification/rot_mem_model.sv */
`timescale 1ns/1ps
module rot_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] val_i,
  output logic [7:0]      rdata_o
);
  logic [1:0] n_q;
  logic [7:0] last_q;
  always @(posedge clk_i)
  begin
    n_q <= (rd_i && !rst_i) ? n_q + 2'h1 : 2'h0;
    last_q <= rst_i ? 8'h00 : rdata_o;
  end
  // byte only in last read clock
  assign rdata_o = (rd_i && n_q == 2'h3) ? val_i : ~last_q;
endmodule : rot_mem_model

/* verification/test_byte_rotate_unit.sv */
`timescale 1ns/1ps
module test_byte_rotate_unit;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  adr_i   = 8'h00;
  logic [31:0] dat_i   = 32'h0;
  logic        we_i    = 1'b0;
  logic [3:0]  sel_i   = 4'h0;
  logic        cyc_i   = 1'b0;
  logic        stb_i   = 1'b0;
  logic [7:0]  mem_val = 8'h00;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic        busy_o;
  logic [63:0] exp_rd[$];
  logic [23:0] exp_mw[$];
  logic [63:0] ev;
  logic [23:0] mw;
  logic [7:0]  r[8];
  logic        wr_seen     = 1'b0;
  int          error_cnt   = 0;
  int          checks_done = 0;
  logic [7:0]  am[6]       = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h00, 8'h18};
  logic [31:0] bad[4]      = '{32'h1605CBFB, 32'h0705CBDD, 32'h000020CB, 32'h0600CCDD};

  always #5 clk_i = ~clk_i;

  byte_rotate_unit i_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i, .busy_o);
  rot_mem_model i_mem (.clk_i, .rst_i, .rd_i(mem_rd_o), .val_i(mem_val),
    .rdata_o(mem_rdata_i));

  task automatic complete_run();
    chk("pending results", 32'h0, 32'(exp_rd.size() + exp_mw.size()));
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rdq(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_rd.push_back({m, e});
    wb(1'b0, a, 32'h0, 4'hF);
  endtask : rdq

  function automatic logic [15:0] rot(input logic [1:0] o, input logic [7:0] v,
                                      input logic [7:0] f);
    logic [7:0] q;
    logic       c;
    case (o)
      2'h0: {c, q} = {v[7], v[6:0], v[7]};
      2'h1: {q, c} = {v[0], v};
      2'h2: {c, q} = {v, f[0]};
      default: {q, c} = {f[0], v};
    endcase
    return {q, q[7], q == 8'h00, f[5], 1'b0, f[3], ~^q, 1'b0, c};
  endfunction : rot

  // a zero count marks a code that must be refused
  task automatic exec(input logic [31:0] code, input logic [7:0] tc);
    wb(1'b1, rot_pkg::OFF_CODE, code, 4'hF);
    wb(1'b1, rot_pkg::OFF_CTRL, 32'h1, 4'hF);
    wb(1'b1, rot_pkg::OFF_BCDE, ~{r[0], r[1], r[2], r[3]}, 4'hF);
    if (tc == 8'h00)
      {r[0], r[1], r[2], r[3]} = ~{r[0], r[1], r[2], r[3]};
    while (busy_o === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    if (tc == 8'h00)
      rdq(rot_pkg::OFF_STATUS, 32'h4, 32'h5);
    else
      rdq(rot_pkg::OFF_STATUS, {16'h0, tc, 8'h02}, 32'hFF07);
    rdq(rot_pkg::OFF_BCDE, {r[0], r[1], r[2], r[3]}, '1);
    rdq(rot_pkg::OFF_HLAF, {r[4], r[5], r[7], r[6]}, '1);
  endtask : exec

  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_rd.size() > 0)
    begin
      ev = exp_rd.pop_front();
      chk("read data", ev[31:0], dat_o & ev[63:32]);
    end
    if (mem_wr_o === 1'b1 && wr_seen === 1'b0 && exp_mw.size() > 0)
    begin
      mw = exp_mw.pop_front();
      chk("memory write", {8'h0, mw}, {8'h0, mem_addr_o, mem_wdata_o});
    end
    wr_seen <= mem_wr_o;
  end

  // runs take about 1530 cycles
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] a;
    logic [15:0] x;
    logic [7:0]  d;
    logic [7:0]  m;
    logic [31:0] code;
    void'($urandom(74304));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (am[i])
      rdq(am[i], 32'h0, '1);
    wb(1'b1, rot_pkg::OFF_BCDE, 32'h11223344, 4'hF);
    wb(1'b1, rot_pkg::OFF_BCDE, 32'hAABBCCDD, 4'h5);
    rdq(rot_pkg::OFF_BCDE, 32'h11BB33DD, '1);
    $display("test reset and lanes done");
    for (int o = 0; o < 4; o++)
      for (int s = 0; s < 8; s++)
        if (s != 6)
        begin
          foreach (r[i])
            r[i] = 8'($urandom);
          wb(1'b1, rot_pkg::OFF_BCDE, {r[0], r[1], r[2], r[3]}, 4'hF);
          wb(1'b1, rot_pkg::OFF_HLAF, {r[4], r[5], r[7], r[6]}, 4'hF);
          x = rot(2'(o), r[s], r[6]);
          r[s] = x[15:8];
          r[6] = x[7:0];
          exec({16'h0, 3'h0, 2'(o), 3'(s), rot_pkg::PFX_CB}, 8'h08);
        end
    $display("test register forms done");
    for (int o = 0; o < 4; o++)
      for (int f = 0; f < 3; f++)
      begin
        foreach (r[i])
          r[i] = 8'($urandom);
        ix = 16'($urandom);
        iy = 16'($urandom);
        d = 8'($urandom);
        m = 8'($urandom);
        mem_val <= m;
        wb(1'b1, rot_pkg::OFF_BCDE, {r[0], r[1], r[2], r[3]}, 4'hF);
        wb(1'b1, rot_pkg::OFF_HLAF, {r[4], r[5], r[7], r[6]}, 4'hF);
        wb(1'b1, rot_pkg::OFF_INDEX, {iy, ix}, 4'hF);
        a = (f == 0) ? {r[4], r[5]} : ((f == 1) ? ix : iy) + {{8{d[7]}}, d};
        x = rot(2'(o), m, r[6]);
        exp_mw.push_back({a, x[15:8]});
        r[6] = x[7:0];
        code = {3'h0, 2'(o), 3'h6, d, rot_pkg::PFX_CB, (f == 1) ? 8'hDD : 8'hFD};
        if (f == 0)
          code = {16'h0, code[31:24], rot_pkg::PFX_CB};
        exec(code, (f == 0) ? 8'h0F : 8'h17);
        rdq(rot_pkg::OFF_INDEX, {iy, ix}, '1);
      end
    $display("test memory forms done");
    foreach (bad[i])
      exec(bad[i], 8'h00);
    $display("test refused codes done");
    repeat (2) @(posedge clk_i);
    complete_run();
  end
endmodule : test_byte_rotate_unit
